// ---- verilog/link_config_registers.sv ----
// Link configuration registers and the pixel, I2C and control channel logic they steer
`timescale 1ns/1ps
`include "link_cfg_map.svh"

// Notes on behaviour
// RQ1 - Bit 6 enables back-channel check generator
// RQ2 - Bit 5 picks pull down or up
// RQ3 - Filter rejects short sync and active pulses
// RQ4 - Bit 3 forwards I2C on address match
// RQ5 - Bit 2 acknowledges I2C writes automatically
// RQ6 - Protected partner always gates pixels by active
// RQ7 - Unprotected partner gates only when bit 1
// RQ8 - Host sets gating before expecting packetized audio
// RQ9 - Overrun transaction ends after 2 ms steps
// RQ10 - Host avoids a zero timeout value
// RQ11 - Bit 0 stops the control channel watchdog
// RQ12 - Pass-all forwards every I2C transaction
// RQ13 - Hold time field in 50 ns steps
// RQ14 - Glitch width field in 5 ns steps
// RQ15 - Fields keep last written value, read back
module link_config_registers
    import link_cfg_pkg::*;
#(
    parameter int TIMEOUT_STEP_CYCLES = `TIMEOUT_STEP_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Pixel path pins
    input wire pix_t pix_i,
    input wire logic partner_protected_i,
    input wire logic two_lane_mode_i,
    output pix_t pix_o,
    // I2C pass-through
    input wire logic i2c_txn_start_i,
    input wire logic i2c_addr_match_i,
    output logic i2c_forward_o,
    output logic i2c_auto_ack_o,
    output logic [2:0] i2c_sda_hold_steps_o,
    output logic [3:0] i2c_glitch_steps_o,
    // Control channel
    input wire logic ctrl_txn_busy_i,
    output logic ctrl_txn_abort_o,
    // Static controls
    output logic backchannel_check_gen_on_o,
    output logic undriven_input_pull_dir_o
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    logic [7:0] gen_cfg_q;
    logic [7:0] gen_cfg_d;
    logic [7:0] timeout_q;
    logic [7:0] timeout_d;
    logic [7:0] i2c_ctl_q;
    logic [7:0] i2c_ctl_d;
    logic expired_seen_q;
    logic expired_seen_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    pix_t pix_s1_q;
    pix_t pix_s2_q;
    logic [1:0] prot_s_q;
    logic [1:0] lane_s_q;
    pix_t pix_out_q;
    pix_t pix_out_d;
    logic forward_q;
    logic forward_d;

    logic wd_running;
    logic wd_expire;
    logic [2:0] filt_len;
    logic [2:0] filt_in;
    logic [2:0] filt_out;
    logic gate_on;
    logic [7:0] status;

    // Register file
    always_comb
    begin
        gen_cfg_d = gen_cfg_q;
        timeout_d = timeout_q;
        i2c_ctl_d = i2c_ctl_q;
        expired_seen_d = expired_seen_q;
        if (reg_wr_i && hit(reg_addr_i, `GEN_CFG_ADDR))
        begin
            gen_cfg_d = reg_wdata_i; // RQ15
        end
        if (reg_wr_i && hit(reg_addr_i, `TIMEOUT_ADDR))
        begin
            timeout_d = reg_wdata_i; // RQ15
        end
        if (reg_wr_i && hit(reg_addr_i, `I2C_CTL_ADDR))
        begin
            i2c_ctl_d = reg_wdata_i; // RQ15
        end
        if (reg_wr_i && hit(reg_addr_i, `STATUS_ADDR) && reg_wdata_i[`STAT_EXPIRED_BIT])
        begin
            expired_seen_d = 1'b0;
        end
        // Set after clear so a same-cycle expiry is never lost
        if (wd_expire)
        begin
            expired_seen_d = 1'b1;
        end
    end

    assign status = {4'h0, expired_seen_q, lane_s_q[1], prot_s_q[1], wd_running};

    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd_i)
        begin
            if (hit(reg_addr_i, `GEN_CFG_ADDR))
            begin
                rdata_d = gen_cfg_q; // RQ15
            end
            else if (hit(reg_addr_i, `TIMEOUT_ADDR))
            begin
                rdata_d = timeout_q; // RQ15
            end
            else if (hit(reg_addr_i, `I2C_CTL_ADDR))
            begin
                rdata_d = i2c_ctl_q; // RQ15
            end
            else if (hit(reg_addr_i, `STATUS_ADDR))
            begin
                rdata_d = status;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            gen_cfg_q <= `GEN_CFG_RESET;
            timeout_q <= `TIMEOUT_RESET;
            i2c_ctl_q <= `I2C_CTL_RESET;
            expired_seen_q <= 1'b0;
            rdata_q <= 8'h00;
        end
        else
        begin
            gen_cfg_q <= gen_cfg_d;
            timeout_q <= timeout_d;
            i2c_ctl_q <= i2c_ctl_d;
            expired_seen_q <= expired_seen_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign backchannel_check_gen_on_o = gen_cfg_q[`GEN_CHECK_GEN_BIT]; // RQ1
    assign undriven_input_pull_dir_o = gen_cfg_q[`GEN_PULL_DIR_BIT]; // RQ2
    assign i2c_auto_ack_o = gen_cfg_q[`GEN_AUTO_ACK_BIT]; // RQ5
    assign i2c_sda_hold_steps_o = i2c_ctl_q[`I2C_HOLD_HI:`I2C_HOLD_LO]; // RQ13
    assign i2c_glitch_steps_o = i2c_ctl_q[`I2C_GLITCH_HI:`I2C_GLITCH_LO]; // RQ14

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            pix_s1_q <= '0;
            pix_s2_q <= '0;
            prot_s_q <= 2'h0;
            lane_s_q <= 2'h0;
        end
        else
        begin
            pix_s1_q <= pix_i;
            pix_s2_q <= pix_s1_q;
            prot_s_q <= {prot_s_q[0], partner_protected_i};
            lane_s_q <= {lane_s_q[0], two_lane_mode_i};
        end
    end

    // Sync and active filtering
    assign filt_len = lane_s_q[1] ? `FILT_LEN_TWO_LANE : `FILT_LEN_ONE_LANE; // RQ3
    assign filt_in = {pix_s2_q.active_video_flag, pix_s2_q.line_sync_pulse, pix_s2_q.frame_sync_pulse};

    for (genvar g = 0; g < 3; g++)
    begin : g_filt
        sync_pulse_filter u_filt
        (
            .clk_sys_i(clk_sys_i),
            .srst_i(srst_i),
            .enable_i(gen_cfg_q[`GEN_FILTER_BIT]),
            .len_i(filt_len),
            .level_i(filt_in[g]),
            .level_o(filt_out[g])
        ); // RQ3
    end

    // Pixel gating; rgb is not delayed to match the filter, so the gate edge lags by the filter length
    assign gate_on = prot_s_q[1] || gen_cfg_q[`GEN_PIX_GATE_BIT]; // RQ6 RQ7 RQ8

    always_comb
    begin
        pix_out_d.active_video_flag = filt_out[2];
        pix_out_d.line_sync_pulse = filt_out[1];
        pix_out_d.frame_sync_pulse = filt_out[0];
        pix_out_d.rgb = pix_s2_q.rgb;
        if (gate_on && !filt_out[2])
        begin
            pix_out_d.rgb = 24'h000000; // RQ6 RQ7
        end
    end

    // I2C forwarding decision
    always_comb
    begin
        forward_d = 1'b0;
        if (i2c_txn_start_i)
        begin
            forward_d = i2c_ctl_q[`I2C_PASS_ALL_BIT] // RQ12
                || (gen_cfg_q[`GEN_PASS_BIT] && i2c_addr_match_i); // RQ4
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            pix_out_q <= '0;
            forward_q <= 1'b0;
        end
        else
        begin
            pix_out_q <= pix_out_d;
            forward_q <= forward_d;
        end
    end

    assign pix_o = pix_out_q;
    assign i2c_forward_o = forward_q;

    // Control channel watchdog
    ctrl_chan_watchdog #(
        .STEP_CYCLES(TIMEOUT_STEP_CYCLES)
    ) u_wdog
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .off_i(timeout_q[`TIMEOUT_OFF_BIT]), // RQ11
        .limit_i(timeout_q[`TIMEOUT_VAL_HI:`TIMEOUT_VAL_LO]), // RQ9 RQ10
        .busy_i(ctrl_txn_busy_i),
        .running_o(wd_running),
        .expire_o(wd_expire)
    );

    assign ctrl_txn_abort_o = wd_expire; // RQ9

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    a_read_gen_cfg: assert property ( // RQ15
        reg_rd_i && hit(reg_addr_i, `GEN_CFG_ADDR) && !reg_wr_i |=> reg_rdata_o == $past(gen_cfg_q))
        else $error("general config read back wrong");

    a_write_then_read: assert property ( // RQ15
        reg_wr_i && hit(reg_addr_i, `I2C_CTL_ADDR) ##1 reg_rd_i && hit(reg_addr_i, `I2C_CTL_ADDR) && !reg_wr_i
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("i2c control write not read back");

    a_check_gen_out: assert property ( // RQ1
        reg_wr_i && hit(reg_addr_i, `GEN_CFG_ADDR)
        |=> backchannel_check_gen_on_o == $past(reg_wdata_i[`GEN_CHECK_GEN_BIT]))
        else $error("check generator enable does not follow write");

    a_pull_auto_ack: assert property ( // RQ2
        reg_wr_i && hit(reg_addr_i, `GEN_CFG_ADDR)
        |=> undriven_input_pull_dir_o == $past(reg_wdata_i[`GEN_PULL_DIR_BIT])
        && i2c_auto_ack_o == $past(reg_wdata_i[`GEN_AUTO_ACK_BIT]))
        else $error("pull direction or auto ack does not follow write");

    a_forward_match: assert property ( // RQ4
        i2c_txn_start_i && i2c_addr_match_i && gen_cfg_q[`GEN_PASS_BIT] |=> i2c_forward_o)
        else $error("matching transaction not forwarded");

    a_forward_blocked: assert property ( // RQ12
        i2c_txn_start_i && !i2c_ctl_q[`I2C_PASS_ALL_BIT] && !(gen_cfg_q[`GEN_PASS_BIT] && i2c_addr_match_i)
        |=> !i2c_forward_o)
        else $error("transaction forwarded without permission");

    a_forward_all: assert property ( // RQ12
        i2c_txn_start_i && i2c_ctl_q[`I2C_PASS_ALL_BIT] |=> i2c_forward_o)
        else $error("pass-all did not forward");

    a_gate_blank: assert property ( // RQ6
        prot_s_q[1] && !filt_out[2] |=> pix_o.rgb == 24'h000000)
        else $error("pixel data passed outside active video");

    a_pass_ungated: assert property ( // RQ7
        !prot_s_q[1] && !gen_cfg_q[`GEN_PIX_GATE_BIT] |=> pix_o.rgb == $past(pix_s2_q.rgb))
        else $error("ungated pixel data altered");

    a_filter_short: assert property ( // RQ3
        gen_cfg_q[`GEN_FILTER_BIT] && !lane_s_q[1] && $stable(gen_cfg_q) && !filt_out[1]
        && !pix_s2_q.line_sync_pulse ##1 pix_s2_q.line_sync_pulse ##1 !pix_s2_q.line_sync_pulse
        |=> !pix_o.line_sync_pulse [*3])
        else $error("one-cycle line sync pulse not rejected");

    a_wdog_off: assert property ( // RQ11
        timeout_q[`TIMEOUT_OFF_BIT] |=> !ctrl_txn_abort_o)
        else $error("watchdog fired while stopped");

    a_abort_pulse: assert property ( // RQ9
        ctrl_txn_abort_o |=> !ctrl_txn_abort_o && expired_seen_q)
        else $error("abort not a single pulse or not recorded");

    a_sticky_set_wins: assert property (
        wd_expire |=> expired_seen_q)
        else $error("expiry lost against clear");

    a_hold_glitch: assert property ( // RQ13
        reg_wr_i && hit(reg_addr_i, `I2C_CTL_ADDR)
        |=> i2c_sda_hold_steps_o == $past(reg_wdata_i[`I2C_HOLD_HI:`I2C_HOLD_LO])
        && i2c_glitch_steps_o == $past(reg_wdata_i[`I2C_GLITCH_HI:`I2C_GLITCH_LO]))
        else $error("hold or glitch field does not follow write");

    c_abort: cover property (ctrl_txn_abort_o);
    c_forward: cover property (i2c_forward_o);
    c_gated: cover property (gate_on && !filt_out[2] && pix_s2_q.rgb != 24'h000000);
    c_two_lane_sync: cover property (lane_s_q[1] && $rose(pix_o.frame_sync_pulse));

endmodule : link_config_registers

// ---- verilog/link_cfg_map.svh ----
// Register offsets, field positions, reset values and timing figures of the link configuration bank
`ifndef LINK_CFG_MAP_SVH
`define LINK_CFG_MAP_SVH

`define GEN_CFG_ADDR 8'h03
`define TIMEOUT_ADDR 8'h04
`define I2C_CTL_ADDR 8'h05
`define STATUS_ADDR 8'h10

`define GEN_CFG_RESET 8'hf0
`define TIMEOUT_RESET 8'hfe
`define I2C_CTL_RESET 8'h1e

`define GEN_CHECK_GEN_BIT 6
`define GEN_PULL_DIR_BIT 5
`define GEN_FILTER_BIT 4
`define GEN_PASS_BIT 3
`define GEN_AUTO_ACK_BIT 2
`define GEN_PIX_GATE_BIT 1

`define TIMEOUT_VAL_HI 7
`define TIMEOUT_VAL_LO 1
`define TIMEOUT_OFF_BIT 0

`define I2C_PASS_ALL_BIT 7
`define I2C_HOLD_HI 6
`define I2C_HOLD_LO 4
`define I2C_GLITCH_HI 3
`define I2C_GLITCH_LO 0

`define STAT_RUN_BIT 0
`define STAT_PROT_BIT 1
`define STAT_LANE_BIT 2
`define STAT_EXPIRED_BIT 3

`define FILT_LEN_ONE_LANE 3'h2
`define FILT_LEN_TWO_LANE 3'h4

`define CLK_PERIOD_NS 25
`define TIMEOUT_STEP_NS 2000000
`define HOLD_STEP_NS 50
`define GLITCH_STEP_NS 5

`endif

// ---- verilog/link_cfg_pkg.sv ----
// Types shared by the link configuration bank and its helpers
package link_cfg_pkg;

    typedef struct packed {
        logic active_video_flag;
        logic line_sync_pulse;
        logic frame_sync_pulse;
        logic [23:0] rgb;
    } pix_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_EXPIRED = 2'b11
    } wd_state_t;

endpackage : link_cfg_pkg

// ---- verilog/sync_pulse_filter.sv ----
// Rejects level changes that do not hold for a programmable number of cycles
`timescale 1ns/1ps
module sync_pulse_filter
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Control
    input wire logic enable_i,
    input wire logic [2:0] len_i,
    // Level
    input wire logic level_i,
    output logic level_o
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic out_q;
    logic out_d;

    always_comb
    begin
        cnt_d = 3'h0;
        out_d = out_q;
        if (!enable_i)
        begin
            out_d = level_i;
        end
        else if (level_i != out_q)
        begin
            if (cnt_q + 3'h1 >= len_i)
            begin
                out_d = level_i;
            end
            else
            begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            cnt_q <= 3'h0;
            out_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign level_o = out_q;

endmodule : sync_pulse_filter

// ---- verilog/ctrl_chan_watchdog.sv ----
// Times a control channel transaction in 2 ms steps and flags an overrun
`timescale 1ns/1ps
`include "link_cfg_map.svh"
module ctrl_chan_watchdog
    import link_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = `TIMEOUT_STEP_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Control
    input wire logic off_i,
    input wire logic [6:0] limit_i,
    input wire logic busy_i,
    // Result
    output logic running_o,
    output logic expire_o
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYCLES - 1);

    wd_state_t state_q;
    wd_state_t state_d;
    logic [CW-1:0] tick_q;
    logic [CW-1:0] tick_d;
    logic [6:0] steps_q;
    logic [6:0] steps_d;
    logic expire_d;
    logic expire_q;

    always_comb
    begin
        state_d = state_q;
        tick_d = tick_q;
        steps_d = steps_q;
        expire_d = 1'b0;
        unique case (state_q)
            WD_IDLE:
            begin
                tick_d = '0;
                steps_d = 7'h0;
                if (busy_i && !off_i)
                begin
                    state_d = WD_RUN;
                end
            end
            WD_RUN:
            begin
                if (!busy_i || off_i)
                begin
                    state_d = WD_IDLE;
                end
                else if (tick_q == STEP_LAST)
                begin
                    tick_d = '0;
                    steps_d = steps_q + 7'h1;
                    // A zero limit acts as one step rather than never firing
                    if (steps_q + 7'h1 >= limit_i)
                    begin
                        expire_d = 1'b1;
                        state_d = WD_EXPIRED;
                    end
                end
                else
                begin
                    tick_d = tick_q + CW'(1);
                end
            end
            WD_EXPIRED:
            begin
                if (!busy_i)
                begin
                    state_d = WD_IDLE;
                end
            end
            default:
            begin
                state_d = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_q <= WD_IDLE;
            tick_q <= '0;
            steps_q <= 7'h0;
            expire_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            tick_q <= tick_d;
            steps_q <= steps_d;
            expire_q <= expire_d;
        end
    end

    assign running_o = (state_q == WD_RUN);
    assign expire_o = expire_q;

endmodule : ctrl_chan_watchdog

// ---- testbench/remote_ser_model.sv ----
// Remote serializer model: runs control channel transactions and reports its protection capability
`timescale 1ns/1ps
module remote_ser_model
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Stimulus from the bench
    input wire logic go_i,
    input wire logic [7:0] len_i,
    input wire logic prot_i,
    // Link side
    input wire logic abort_i,
    output logic busy_o,
    output logic prot_o
);
    logic [7:0] cnt_q;

    assign prot_o = prot_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            busy_o <= 1'b0;
            cnt_q <= 8'h00;
        end
        else if (go_i)
        begin
            busy_o <= 1'b1;
            cnt_q <= len_i;
        end
        else if (busy_o)
        begin
            // A terminated transaction is dropped at once, like the real far side
            if (abort_i || cnt_q == 8'h01)
                busy_o <= 1'b0;
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : remote_ser_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the link configuration register bank
`timescale 1ns/1ps
module tb_top;
    import link_cfg_pkg::*;
    localparam int STEP = 4;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    pix_t pix_in = '0;
    pix_t pix_out;
    logic prot = 1'b0;
    logic prot_pin;
    logic two_lane = 1'b0;
    logic start = 1'b0;
    logic match = 1'b0;
    logic fwd, auto_ack, chk_gen, pull_dir, busy, abort;
    logic go = 1'b0;
    logic [7:0] len = 8'h00;
    logic [2:0] hold;
    logic [3:0] glitch;
    int failures = 0;
    int compares = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    link_config_registers #(.TIMEOUT_STEP_CYCLES(STEP)) i_link_config_registers (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pix_i(pix_in),
        .partner_protected_i(prot_pin), .two_lane_mode_i(two_lane), .pix_o(pix_out),
        .i2c_txn_start_i(start), .i2c_addr_match_i(match), .i2c_forward_o(fwd),
        .i2c_auto_ack_o(auto_ack), .i2c_sda_hold_steps_o(hold), .i2c_glitch_steps_o(glitch),
        .ctrl_txn_busy_i(busy), .ctrl_txn_abort_o(abort),
        .backchannel_check_gen_on_o(chk_gen), .undriven_input_pull_dir_o(pull_dir));

    remote_ser_model i_remote_ser_model (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .go_i(go), .len_i(len), .prot_i(prot),
        .abort_i(abort), .busy_o(busy), .prot_o(prot_pin));

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Called just after an edge, so a write and a read may follow each other with no gap
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : wait_cycles

    // Drives a pulse of w cycles on all three flags and reports which flags reached the output
    task automatic pulse(input int w, output logic [2:0] seen);
        seen = 3'h0;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk_sys_i);
            pix_in.active_video_flag <= (i < w);
            pix_in.line_sync_pulse <= (i < w);
            pix_in.frame_sync_pulse <= (i < w);
            #1;
            seen = seen | {pix_out.active_video_flag, pix_out.line_sync_pulse, pix_out.frame_sync_pulse};
        end
    endtask : pulse

    initial
    begin
        logic [7:0] d;
        logic [2:0] seen;
        int n;
        logic [7:0] pats [2] = '{8'h5a, 8'ha5};
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1;
        check("check_gen rst", chk_gen, 1'b1);
        check("pull_dir rst", pull_dir, 1'b1);
        check("auto_ack rst", auto_ack, 1'b0);
        check("hold rst", hold, 3'h1);
        check("glitch rst", glitch, 4'he);
        reg_rd(8'h03, d);
        check("gen rst", d, 8'hf0);
        reg_rd(8'h04, d);
        check("timeout rst", d, 8'hfe);
        reg_rd(8'h05, d);
        check("i2c rst", d, 8'h1e);
        $display("test reset done");

        foreach (pats[k])
        begin
            for (int a = 3; a <= 5; a++)
            begin
                reg_wr(a[7:0], pats[k]);
                reg_rd(a[7:0], d);
                check("readback", d, pats[k]);
            end
            check("check_gen", chk_gen, pats[k][6]);
            check("pull_dir", pull_dir, pats[k][5]);
            check("auto_ack", auto_ack, pats[k][2]);
            check("hold", hold, pats[k][6:4]);
            check("glitch", glitch, pats[k][3:0]);
        end
        reg_wr(8'h20, 8'hff);
        reg_rd(8'h20, d);
        check("unmapped", d, 8'h00);
        reg_rd(8'h05, d);
        check("i2c kept", d, 8'ha5);
        $display("test registers done");

        for (int i = 0; i < 8; i++)
        begin
            reg_wr(8'h03, 8'hf0 | {4'h0, i[1], 3'h0});
            reg_wr(8'h05, {i[2], 7'h1e});
            @(posedge clk_sys_i);
            start <= 1'b1;
            match <= i[0];
            @(posedge clk_sys_i);
            start <= 1'b0;
            #1;
            check("forward", fwd, i[2] | (i[1] & i[0]));
        end
        $display("test forward done");

        pix_in.rgb <= 24'habcdef;
        for (int i = 0; i < 4; i++)
        begin
            prot <= i[1];
            // Gating is set first so packetized audio may follow
            reg_wr(8'h03, 8'hf0 | {6'h0, i[0], 1'b0});
            wait_cycles(8);
            check("rgb gated", pix_out.rgb, (i[1] | i[0]) ? 24'h0 : 24'habcdef);
        end
        prot <= 1'b0;
        $display("test gating done");

        for (int l = 0; l < 2; l++)
        begin
            n = l ? 4 : 2;
            two_lane <= l[0];
            wait_cycles(4);
            pulse(n - 1, seen);
            check("short pulse", seen, 3'h0);
            pulse(n + 2, seen);
            check("long pulse", seen, 3'h7);
        end
        reg_wr(8'h03, 8'he0);
        pulse(1, seen);
        check("unfiltered", seen, 3'h7);
        $display("test filter done");

        // A nonzero limit of two steps
        reg_wr(8'h04, 8'h04);
        @(posedge clk_sys_i);
        go <= 1'b1;
        len <= 8'h64;
        @(posedge clk_sys_i);
        go <= 1'b0;
        n = 0;
        #1;
        while (abort !== 1'b1)
        begin
            n++;
            if (n > 40)
            begin
                failures++;
                $display("BAD abort wait expected pulse seen none");
                break;
            end
            wait_cycles(1);
        end
        check("abort early", n >= 2 * STEP - 1, 1'b1);
        check("abort late", n <= 2 * STEP + 3, 1'b1);
        // Sticky overrun flag lands one cycle after the abort pulse; two-lane is still selected
        wait_cycles(2);
        reg_rd(8'h10, d);
        check("status expired", d, 8'h0c);
        reg_wr(8'h10, 8'h08);
        reg_rd(8'h10, d);
        check("status cleared", d, 8'h04);
        for (int m = 0; m < 2; m++)
        begin
            reg_wr(8'h04, m ? 8'h04 : 8'h05);
            @(posedge clk_sys_i);
            go <= 1'b1;
            len <= m ? 8'h03 : 8'h1e;
            @(posedge clk_sys_i);
            go <= 1'b0;
            seen = 1'b0;
            repeat (36)
            begin
                wait_cycles(1);
                if (abort === 1'b1)
                    seen = 1'b1;
            end
            check("no abort", seen, 1'b0);
        end
        $display("test watchdog done");
        end_of_test();
    end
endmodule : tb_top
